// file: hw/xo_pkg.sv
// Shared constants and types for the exclusive-OR execution block.
// Assumes a 16-bit memory bus that answers each request with an ack.
package xo_pkg;

    // Opcode byte 50h..57h: bits 7:3 select the family
    localparam logic [4:0] XO_OPC_FAMILY = 5'h0a;
    localparam int XO_OPC_MSB = 15;
    localparam int XO_OPC_LSB = 8;
    localparam int XO_RS_MSB = 7;
    localparam int XO_RS_LSB = 4;
    localparam int XO_RD_MSB = 3;
    localparam int XO_RD_LSB = 0;

    // Operand forms, opcode bits 2:1: bit 0 memory destination,
    // bit 1 immediate source
    localparam logic [1:0] XO_FORM_RR = 2'h0;
    localparam logic [1:0] XO_FORM_RM = 2'h1;
    localparam logic [1:0] XO_FORM_IR = 2'h2;
    localparam logic [1:0] XO_FORM_IM = 2'h3;
    localparam int XO_FORM_MEM_BIT = 0;
    localparam int XO_FORM_IMM_BIT = 1;

    // Address steps from the instruction address
    localparam logic [15:0] XO_STEP_W1 = 16'h0004;
    localparam logic [15:0] XO_STEP_W2 = 16'h0006;
    localparam logic [15:0] XO_STEP_W3 = 16'h0008;

    // Bus cycle codes, bits w b f d
    localparam logic [3:0] XO_WBFD_FETCH = 4'h8;
    localparam logic [3:0] XO_WBFD_EXT = 4'h9;
    localparam logic [3:0] XO_WBFD_INTERNAL = 4'hb;
    localparam logic [3:0] XO_WBFD_RD_W = 4'hb;
    localparam logic [3:0] XO_WBFD_RD_B = 4'hf;
    localparam logic [3:0] XO_WBFD_WR_W = 4'h3;
    localparam logic [3:0] XO_WBFD_WR_B = 4'h7;

    // Register file
    localparam int XO_RF_DEPTH = 16;
    localparam logic [3:0] XO_FLAG_REG = 4'he;
    localparam logic [3:0] XO_ZERO_REG = 4'hf;
    localparam logic [15:0] XO_RF_RESET = 16'h0000;

    // Flag word layout
    localparam int XO_FLAG_N = 15;
    localparam int XO_FLAG_Z = 14;
    localparam int XO_FLAG_C = 13;
    localparam int XO_FLAG_V = 12;
    localparam logic [15:0] XO_FLAG_MASK = 16'hd000;

    localparam logic [7:0] XO_BYTE_ZERO = 8'h00;

    typedef enum logic [2:0] {
        XO_S_IDLE,
        XO_S_FETCH_OFS,
        XO_S_FETCH_LIT,
        XO_S_RD_MEM,
        XO_S_INTERNAL,
        XO_S_WR_MEM,
        XO_S_FETCH_NEXT
    } xo_state_t;

endpackage

// file: hw/xo_rf_if.sv
// Interface between the execution core and its register file.
// Assumes one clock; reads are combinational, writes land on the edge.
`timescale 1ns/1ns
interface xo_rf_if;
    logic [3:0] rd_addr_a;
    logic [3:0] rd_addr_b;
    logic [3:0] rd_addr_c;
    logic [15:0] rd_data_a;
    logic [15:0] rd_data_b;
    logic [15:0] rd_data_c;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [15:0] wr_data;
    logic flg_en;
    logic flg_z;
    logic flg_n;

    modport core (
        output rd_addr_a, rd_addr_b, rd_addr_c,
        input rd_data_a, rd_data_b, rd_data_c,
        output wr_en, wr_addr, wr_data, flg_en, flg_z, flg_n
    );
    modport rf (
        input rd_addr_a, rd_addr_b, rd_addr_c,
        output rd_data_a, rd_data_b, rd_data_c,
        input wr_en, wr_addr, wr_data, flg_en, flg_z, flg_n
    );
endinterface

// file: hw/xo_regfile.sv
// Sixteen-entry, 16-bit register file with flag word in entry fourteen.
// Assumes at most one data write per cycle; flag bits override that write.
`timescale 1ns/1ns
module xo_regfile
    import xo_pkg::*;
(
    input wire logic i_clk, // core clock
    input wire logic i_rst_b, // async reset, active low
    xo_rf_if.rf rf // core access
);
    logic [15:0] regs_q [XO_RF_DEPTH];
    wire [15:0] flag_bits = (16'(rf.flg_n) << XO_FLAG_N)
                          | (16'(rf.flg_z) << XO_FLAG_Z);

    genvar g;
    for (g = 0; g < XO_RF_DEPTH; g++) begin : g_ent
        wire hit = rf.wr_en && (rf.wr_addr == 4'(g));
        wire [15:0] base = hit ? rf.wr_data : regs_q[g];
        // Carry and other bits kept, overflow forced low
        wire [15:0] nxt = (rf.flg_en && (4'(g) == XO_FLAG_REG))
                        ? ((base & ~XO_FLAG_MASK) | flag_bits) : base;
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                regs_q[g] <= XO_RF_RESET;
            end else if (4'(g) != XO_ZERO_REG) begin
                regs_q[g] <= nxt;
            end
        end
    end

    assign rf.rd_data_a = regs_q[rf.rd_addr_a];
    assign rf.rd_data_b = regs_q[rf.rd_addr_b];
    assign rf.rd_data_c = regs_q[rf.rd_addr_c];
endmodule // xo_regfile

// file: hw/xo_alu.sv
// Exclusive-OR datapath with size-aware zero and negative results.
// Purely combinational; the caller registers what it keeps.
`timescale 1ns/1ns
module xo_alu
    import xo_pkg::*;
(
    input wire logic [15:0] i_src, // source operand
    input wire logic [15:0] i_dst, // destination operand
    input wire logic i_byte, // byte form
    output logic [15:0] o_result, // word result
    output logic o_zero, // result is zero
    output logic o_neg // sign of result at operation size
);
    // Byte operands zero-extended, so the upper byte comes out zero
    wire [15:0] src_ext = i_byte ? {XO_BYTE_ZERO, i_src[7:0]} : i_src;
    wire [15:0] dst_ext = i_byte ? {XO_BYTE_ZERO, i_dst[7:0]} : i_dst;

    assign o_result = src_ext ^ dst_ext;
    assign o_zero = (o_result == 16'h0000);
    assign o_neg = i_byte ? o_result[7] : o_result[15];
endmodule // xo_alu

// file: hw/xo_exec.sv
// Execution unit for the word and byte exclusive-OR instructions.
// Assumes a synchronous memory bus: a request stands until acked.
//
// Behaviour
// - Destination receives source XOR destination.
// - Forms: reg-reg, reg-mem, literal-reg, literal-mem (offset plus base).
// - Zero flag set on zero result, cleared otherwise.
// - Negative flag is the result's top bit at operation size.
// - Carry unchanged, overflow forced to zero.
// - Byte form zero-extends both operands and computes on words.
// - Byte-form result has an upper byte of zero.
// - Memory gets low byte for byte form; registers get full word.
// - Flags evaluated at byte or word size.
// - Opcodes 50h-57h: even word, odd byte, forms in order.
// - Reg-reg form is one bus cycle fetching at address plus four.
// - Memory forms read, run internal cycle, write back same address.
// - Sixteen 16-bit registers; flag word lives in register fourteen.
`timescale 1ns/1ns
module xo_exec
    import xo_pkg::*;
(
    input wire logic i_clk, // core clock, 250 MHz
    input wire logic i_rst_b, // async reset, active low
    input wire logic i_start, // begin instruction, pulse
    input wire logic [15:0] i_opcode, // opcode word: op, src, dst
    input wire logic [15:0] i_op_addr, // instruction_address
    input wire logic i_abort, // abandon current instruction
    input wire logic i_bus_ack, // bus cycle complete, pulse
    input wire logic [15:0] i_bus_rdata, // bus read data
    input wire logic i_rf_wr, // load register, idle only
    input wire logic [3:0] i_rf_waddr, // load register index
    input wire logic [15:0] i_rf_wdata, // load register value
    input wire logic [3:0] i_rf_raddr, // readback register index
    output logic o_bus_req, // bus cycle request
    output logic [15:0] o_bus_addr, // bus address
    output logic o_bus_wr, // bus write
    output logic o_bus_byte, // byte-sized data cycle
    output logic [15:0] o_bus_wdata, // bus write data
    output logic [3:0] o_bus_wbfd, // bus cycle code
    output logic o_busy, // instruction in progress
    output logic o_done, // instruction finished, pulse
    output logic o_illegal, // start with foreign opcode
    output logic [15:0] o_next_word, // next_fetch_word
    output logic [15:0] o_rf_rdata // readback data
);
    xo_state_t state_q;
    xo_state_t state_d;
    logic [1:0] form_q;
    logic byte_q;
    logic [3:0] rd_idx_q;
    logic [15:0] rs_val_q;
    logic [15:0] rd_val_q;
    logic [15:0] opa_q;
    logic [15:0] ofs_q;
    logic [15:0] lit_q;
    logic [15:0] mem_addr_q;
    logic [15:0] mem_data_q;
    logic bus_req_q;
    logic [15:0] bus_addr_q;
    logic bus_wr_q;
    logic bus_byte_q;
    logic [15:0] bus_wdata_q;
    logic [3:0] bus_wbfd_q;
    logic busy_q;
    logic done_q;
    logic illegal_q;
    logic [15:0] next_word_q;
    logic [15:0] rf_rdata_q;

    logic [15:0] addr_d;
    logic [3:0] wbfd_d;
    logic wr_d;
    logic byte_d;

    xo_rf_if rf_bus ();

    // Decode of the incoming opcode
    wire [7:0] opc = i_opcode[XO_OPC_MSB:XO_OPC_LSB];
    wire opc_hit = (opc[7:3] == XO_OPC_FAMILY);
    wire [1:0] start_form = opc[2:1];
    wire start_byte = opc[0];
    wire is_idle = (state_q == XO_S_IDLE);
    wire start_go = i_start && opc_hit && is_idle;
    wire bus_step = bus_req_q && i_bus_ack;
    wire abort_go = i_abort && !is_idle;

    // Values that apply from the start edge onward
    wire [1:0] form_cur = is_idle ? start_form : form_q;
    wire [15:0] opa_cur = is_idle ? i_op_addr : opa_q;
    wire mem_dst = form_q[XO_FORM_MEM_BIT];
    wire imm_src = form_q[XO_FORM_IMM_BIT];

    // Offset may still be on the bus when the read is issued
    wire [15:0] ofs_cur = (state_q == XO_S_FETCH_OFS) ? i_bus_rdata : ofs_q;
    wire [15:0] mem_addr_new = ofs_cur + rd_val_q;

    wire [15:0] lit_step = (form_cur == XO_FORM_IM) ? XO_STEP_W2 : XO_STEP_W1;
    wire [15:0] next_step = (form_cur == XO_FORM_RR) ? XO_STEP_W1 :
                            (form_cur == XO_FORM_IM) ? XO_STEP_W3 :
                            XO_STEP_W2;

    // Byte literal keeps only its low byte; the ALU zero-extends it
    wire [15:0] src_val = imm_src ? lit_q : rs_val_q;
    wire [15:0] dst_val = mem_dst ? mem_data_q : rd_val_q;
    wire [15:0] mem_rd_val = byte_q ? {XO_BYTE_ZERO, i_bus_rdata[7:0]}
                                    : i_bus_rdata;

    logic [15:0] alu_result;
    logic alu_zero;
    logic alu_neg;

    xo_alu u_alu (
        .i_src(src_val),
        .i_dst(dst_val),
        .i_byte(byte_q),
        .o_result(alu_result),
        .o_zero(alu_zero),
        .o_neg(alu_neg)
    );

    // Register forms commit on the onward fetch ack; memory forms
    // commit flags on the write-back ack, so an earlier abort
    // leaves the flag word alone
    wire commit_reg = bus_step && !abort_go && !mem_dst
                    && (state_q == XO_S_FETCH_NEXT);
    wire commit_mem = bus_step && !abort_go && mem_dst
                    && (state_q == XO_S_WR_MEM);
    wire host_wr = i_rf_wr && is_idle;

    wire [15:0] wr_mem_data = byte_q ? {XO_BYTE_ZERO, alu_result[7:0]}
                                     : alu_result;

    assign rf_bus.rd_addr_a = i_opcode[XO_RS_MSB:XO_RS_LSB];
    assign rf_bus.rd_addr_b = i_opcode[XO_RD_MSB:XO_RD_LSB];
    assign rf_bus.rd_addr_c = i_rf_raddr;
    assign rf_bus.wr_en = commit_reg || host_wr;
    assign rf_bus.wr_addr = commit_reg ? rd_idx_q : i_rf_waddr;
    assign rf_bus.wr_data = commit_reg ? alu_result : i_rf_wdata;
    assign rf_bus.flg_en = commit_reg || commit_mem;
    assign rf_bus.flg_z = alu_zero;
    assign rf_bus.flg_n = alu_neg;

    xo_regfile u_rf (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .rf(rf_bus)
    );

    // Sequencer: one state per bus cycle
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            XO_S_IDLE: begin
                if (start_go) begin
                    unique case (start_form)
                        XO_FORM_RR: state_d = XO_S_FETCH_NEXT;
                        XO_FORM_RM: state_d = XO_S_FETCH_OFS;
                        XO_FORM_IR: state_d = XO_S_FETCH_LIT;
                        XO_FORM_IM: state_d = XO_S_FETCH_OFS;
                    endcase
                end
            end
            XO_S_FETCH_OFS: begin
                if (bus_step) begin
                    state_d = (form_q == XO_FORM_IM) ? XO_S_FETCH_LIT
                                                     : XO_S_RD_MEM;
                end
            end
            XO_S_FETCH_LIT: begin
                if (bus_step) begin
                    state_d = (form_q == XO_FORM_IM) ? XO_S_RD_MEM
                                                     : XO_S_FETCH_NEXT;
                end
            end
            XO_S_RD_MEM: begin
                if (bus_step) begin
                    state_d = XO_S_INTERNAL;
                end
            end
            XO_S_INTERNAL: begin
                if (bus_step) begin
                    state_d = XO_S_WR_MEM;
                end
            end
            XO_S_WR_MEM: begin
                if (bus_step) begin
                    state_d = XO_S_FETCH_NEXT;
                end
            end
            XO_S_FETCH_NEXT: begin
                if (bus_step) begin
                    state_d = XO_S_IDLE;
                end
            end
        endcase
        if (abort_go) begin
            state_d = XO_S_IDLE;
        end
    end

    // Bus fields for the next cycle; held while it waits for ack,
    // so the registered copy stays put
    always_comb begin
        addr_d = bus_addr_q;
        wbfd_d = XO_WBFD_FETCH;
        wr_d = 1'b0;
        byte_d = 1'b0;
        unique case (state_d)
            XO_S_IDLE: begin
                addr_d = bus_addr_q;
            end
            XO_S_FETCH_OFS: begin
                addr_d = opa_cur + XO_STEP_W1;
                wbfd_d = XO_WBFD_EXT;
            end
            XO_S_FETCH_LIT: begin
                addr_d = opa_cur + lit_step;
                wbfd_d = XO_WBFD_EXT;
            end
            XO_S_RD_MEM: begin
                addr_d = mem_addr_new;
                wbfd_d = byte_q ? XO_WBFD_RD_B : XO_WBFD_RD_W;
                byte_d = byte_q;
            end
            XO_S_INTERNAL: begin
                addr_d = bus_addr_q; // prior_bus_address
                wbfd_d = XO_WBFD_INTERNAL;
            end
            XO_S_WR_MEM: begin
                addr_d = mem_addr_q;
                wbfd_d = byte_q ? XO_WBFD_WR_B : XO_WBFD_WR_W;
                wr_d = 1'b1;
                byte_d = byte_q;
            end
            XO_S_FETCH_NEXT: begin
                addr_d = opa_cur + next_step;
                wbfd_d = XO_WBFD_FETCH;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= XO_S_IDLE;
            bus_req_q <= 1'b0;
            bus_addr_q <= 16'h0000;
            bus_wr_q <= 1'b0;
            bus_byte_q <= 1'b0;
            bus_wbfd_q <= XO_WBFD_FETCH;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bus_req_q <= (state_d != XO_S_IDLE);
            bus_addr_q <= addr_d;
            bus_wr_q <= wr_d;
            bus_byte_q <= byte_d;
            bus_wbfd_q <= wbfd_d;
            busy_q <= (state_d != XO_S_IDLE);
        end
    end

    // Operand capture at start
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            form_q <= XO_FORM_RR;
            byte_q <= 1'b0;
            rd_idx_q <= 4'h0;
            rs_val_q <= 16'h0000;
            rd_val_q <= 16'h0000;
            opa_q <= 16'h0000;
        end else if (start_go) begin
            form_q <= start_form;
            byte_q <= start_byte;
            rd_idx_q <= i_opcode[XO_RD_MSB:XO_RD_LSB];
            rs_val_q <= rf_bus.rd_data_a;
            rd_val_q <= rf_bus.rd_data_b;
            opa_q <= i_op_addr;
        end
    end

    // Extension words and memory operand
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ofs_q <= 16'h0000;
            lit_q <= 16'h0000;
            mem_addr_q <= 16'h0000;
            mem_data_q <= 16'h0000;
        end else if (bus_step) begin
            if (state_q == XO_S_FETCH_OFS) begin
                ofs_q <= i_bus_rdata;
            end
            if (state_q == XO_S_FETCH_LIT) begin
                lit_q <= i_bus_rdata;
            end
            if (state_q == XO_S_RD_MEM) begin
                mem_addr_q <= bus_addr_q;
                mem_data_q <= mem_rd_val;
            end
        end
    end

    // Write data is loaded as the write cycle is entered
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_wdata_q <= 16'h0000;
        end else if (state_d == XO_S_WR_MEM && state_q != XO_S_WR_MEM) begin
            bus_wdata_q <= wr_mem_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_q <= 1'b0;
            illegal_q <= 1'b0;
            next_word_q <= 16'h0000;
            rf_rdata_q <= 16'h0000;
        end else begin
            done_q <= commit_reg || (bus_step && !abort_go
                      && mem_dst && state_q == XO_S_FETCH_NEXT);
            illegal_q <= i_start && is_idle && !opc_hit;
            rf_rdata_q <= rf_bus.rd_data_c;
            if (bus_step && state_q == XO_S_FETCH_NEXT) begin
                next_word_q <= i_bus_rdata;
            end
        end
    end

    assign o_bus_req = bus_req_q;
    assign o_bus_addr = bus_addr_q;
    assign o_bus_wr = bus_wr_q;
    assign o_bus_byte = bus_byte_q;
    assign o_bus_wdata = bus_wdata_q;
    assign o_bus_wbfd = bus_wbfd_q;
    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_illegal = illegal_q;
    assign o_next_word = next_word_q;
    assign o_rf_rdata = rf_rdata_q;
endmodule // xo_exec

// file: sim/xo_exec_props.sv
// Port-level checks for the exclusive-OR execution unit.
// Assumes one clock domain and the request/ack bus of xo_exec.
`timescale 1ns/1ns
module xo_exec_props
    import xo_pkg::*;
(
    input wire logic i_clk, // core clock
    input wire logic i_rst_b, // async reset, active low
    input wire logic i_start, // begin instruction
    input wire logic [15:0] i_opcode, // opcode word
    input wire logic i_abort, // abandon instruction
    input wire logic i_bus_ack, // bus cycle complete
    input wire logic o_bus_req, // bus request
    input wire logic [15:0] o_bus_addr, // bus address
    input wire logic o_bus_wr, // bus write
    input wire logic o_bus_byte, // byte data cycle
    input wire logic [15:0] o_bus_wdata, // write data
    input wire logic [3:0] o_bus_wbfd, // cycle code
    input wire logic o_busy, // in progress
    input wire logic o_done, // finished pulse
    input wire logic o_illegal // foreign opcode pulse
);
    logic [15:0] rd_addr_q;
    logic idle_start;
    assign idle_start = i_start && !o_busy && !o_done && !o_illegal;

    // Data-read address, so the write-back can be tied to it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_addr_q <= 16'h0000;
        end else if (o_bus_req && i_bus_ack && !o_bus_wr
                     && o_bus_wbfd[1:0] == 2'h3) begin
            rd_addr_q <= o_bus_addr;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_req_stands: assert property (
        o_bus_req && !i_bus_ack && !i_abort |=> o_bus_req
        && $stable({o_bus_addr, o_bus_wbfd, o_bus_wr, o_bus_wdata}))
        else $error("bus request changed before its ack");
    a_start_busy: assert property (
        idle_start && i_opcode[15:11] == XO_OPC_FAMILY
        |=> o_busy && o_bus_req && !o_illegal)
        else $error("valid opcode did not start");
    a_bad_opcode: assert property (
        idle_start && i_opcode[15:11] != XO_OPC_FAMILY
        |=> o_illegal && !o_busy && !o_bus_req)
        else $error("foreign opcode not refused");
    a_fetch_done: assert property (
        o_bus_req && i_bus_ack && !i_abort && o_bus_wbfd == XO_WBFD_FETCH
        |=> o_done && !o_busy)
        else $error("no done after final fetch");
    a_done_cause: assert property (
        o_done |-> $past(o_bus_req && i_bus_ack
        && o_bus_wbfd == XO_WBFD_FETCH))
        else $error("done without fetch ack");
    a_write_code: assert property (
        o_bus_req && o_bus_wr
        |-> o_bus_wbfd == (o_bus_byte ? XO_WBFD_WR_B : XO_WBFD_WR_W))
        else $error("write cycle code wrong");
    a_byte_upper: assert property (
        o_bus_req && o_bus_wr && o_bus_byte
        |-> o_bus_wdata[15:8] == XO_BYTE_ZERO)
        else $error("byte write upper byte not zero");
    a_wr_addr: assert property (
        o_bus_req && o_bus_wr |-> o_bus_addr == rd_addr_q)
        else $error("write-back address differs from read");
    a_rmw_order: assert property (
        o_bus_req && $rose(o_bus_wr)
        |-> $past(o_bus_req && o_bus_wbfd == XO_WBFD_INTERNAL))
        else $error("write not preceded by internal cycle");
    a_after_write: assert property (
        o_bus_req && i_bus_ack && o_bus_wr && !i_abort
        |=> o_bus_req && !o_bus_wr && o_bus_wbfd == XO_WBFD_FETCH)
        else $error("no fetch after write-back");
    a_abort_idle: assert property (
        o_busy && i_abort |=> !o_busy && !o_bus_req && !o_done)
        else $error("abort did not return to idle");
endmodule // xo_exec_props

bind xo_exec xo_exec_props i_props (.*);

// file: sim/xo_mem_model.sv
// Memory bus partner: read data is the address XORed with a key.
// Assumes the bench checks write cycles on the bus itself.
`timescale 1ns/1ns
module xo_mem_model (
    input wire logic i_clk,          // core clock
    input wire logic i_rst_b,        // async reset, active low
    input wire logic i_req,          // request level
    input wire logic [15:0] i_addr,  // request address
    input wire logic [15:0] i_key,   // read pattern key
    input wire logic i_slow,         // random wait states
    output logic o_ack,              // cycle complete
    output logic [15:0] o_rdata      // read data
);
    logic [1:0] wait_q;
    logic [15:0] last_q;
    assign o_ack = i_req && wait_q == 2'h0;
    // Off the ack cycle the lines show junk
    assign o_rdata = o_ack ? i_addr ^ i_key : ~last_q;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_q <= 2'h0;
            last_q <= 16'h0000;
        end else if (o_ack) begin
            wait_q <= i_slow ? 2'($urandom_range(3, 0)) : 2'h0;
            last_q <= o_rdata;
        end else if (i_req) begin
            wait_q <= wait_q - 2'h1;
        end
    end
endmodule // xo_mem_model

// file: sim/tb_top.sv
// Self-checking bench for xo_exec with a keyed memory partner.
// Assumes xo_pkg, the design files and the checker are compiled first.
`timescale 1ns/1ns
module tb_top;
    import xo_pkg::*;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_start = 1'b0, i_abort = 1'b0;
    logic i_rf_wr = 1'b0, slow = 1'b0;
    logic [15:0] i_opcode = 16'h0000, i_op_addr = 16'h0000;
    logic [15:0] i_rf_wdata = 16'h0000, key = 16'h0000;
    logic [3:0] i_rf_waddr = 4'h0, i_rf_raddr = 4'h0, o_bus_wbfd;
    logic i_bus_ack, o_bus_req, o_bus_wr, o_bus_byte, o_busy, o_done;
    logic o_illegal;
    logic [15:0] i_bus_rdata, o_bus_addr, o_bus_wdata, o_next_word;
    logic [15:0] o_rf_rdata;
    logic [15:0] rf [16];
    logic [37:0] expq [$];
    int n_errors = 0, comparisons = 0, cyc = 0;

    always #2 i_clk = ~i_clk;

    xo_exec i_xo_exec (.*);
    xo_mem_model i_xo_mem_model (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(o_bus_req),
        .i_addr(o_bus_addr), .i_key(key), .i_slow(slow),
        .o_ack(i_bus_ack), .o_rdata(i_bus_rdata));

    task automatic finish_test;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [37:0] got, input logic [37:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [37:0] ent(logic [15:0] a, logic [3:0] c,
                                        logic w, logic bt, logic [15:0] d);
        return {a, c, w, bt, w ? d : 16'h0000};
    endfunction

    function automatic logic [15:0] flags(logic [15:0] old,
                                          logic [15:0] r, logic b);
        return {b ? r[7] : r[15], b ? r[7:0] == 8'h00 : r == 16'h0000,
                old[13], 1'b0, old[11:0]};
    endfunction

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test;
        end
    end

    // Every completed bus cycle must be the next one expected
    always @(negedge i_clk) begin
        if (o_bus_req === 1'b1 && i_bus_ack === 1'b1) begin
            if (expq.size() == 0) check(38'h1, 38'h0);
            else check(ent(o_bus_addr, o_bus_wbfd, o_bus_wr, o_bus_byte,
                           o_bus_wdata), expq.pop_front());
        end
    end

    task automatic load(input logic [3:0] idx, input logic [15:0] val);
        @(negedge i_clk);
        i_rf_wr = 1'b1;
        i_rf_waddr = idx;
        i_rf_wdata = val;
        @(negedge i_clk);
        i_rf_wr = 1'b0;
        if (idx != 4'hf) rf[idx] = val;
    endtask

    task automatic rd_chk(input logic [3:0] idx);
        @(negedge i_clk);
        i_rf_raddr = idx;
        @(negedge i_clk);
        check(o_rf_rdata, rf[idx]);
    endtask

    task automatic run(input logic [7:0] op, input logic [3:0] rs,
                       input logic [3:0] rd, input int abort_at);
        logic [15:0] instruction_address, ofs, lit, ma, src, dst, res, fa;
        logic [1:0] form;
        logic b;
        int acks;
        instruction_address = 16'($urandom) & 16'hfffe;
        key = 16'($urandom);
        slow = 1'($urandom);
        load(rs, 16'($urandom));
        load(rd, 16'($urandom));
        load(4'he, 16'($urandom));
        load(4'hf, 16'($urandom));
        form = op[2:1];
        b = op[0];
        ofs = (instruction_address + XO_STEP_W1) ^ key;
        lit = form == XO_FORM_IM ? (instruction_address + XO_STEP_W2) ^ key : ofs;
        ma = ofs + rf[rd];
        src = form[XO_FORM_IMM_BIT] ? lit : rf[rs];
        dst = form[XO_FORM_MEM_BIT] ? ma ^ key : rf[rd];
        if (b) begin
            src[15:8] = XO_BYTE_ZERO;
            dst[15:8] = XO_BYTE_ZERO;
        end
        res = src ^ dst;
        fa = instruction_address + (form == XO_FORM_RR ? XO_STEP_W1 :
                    form == XO_FORM_IM ? XO_STEP_W3 : XO_STEP_W2);
        expq = {};
        if (form != XO_FORM_RR) expq.push_back(ent(instruction_address + XO_STEP_W1,
                                               XO_WBFD_EXT, 0, 0, 0));
        if (form == XO_FORM_IM) expq.push_back(ent(instruction_address + XO_STEP_W2,
                                               XO_WBFD_EXT, 0, 0, 0));
        if (form[XO_FORM_MEM_BIT]) begin
            expq.push_back(ent(ma, b ? XO_WBFD_RD_B : XO_WBFD_RD_W, 0, b, 0));
            expq.push_back(ent(ma, XO_WBFD_INTERNAL, 0, 0, 0));
            expq.push_back(ent(ma, b ? XO_WBFD_WR_B : XO_WBFD_WR_W, 1, b, res));
        end
        expq.push_back(ent(fa, XO_WBFD_FETCH, 0, 0, 0));
        @(negedge i_clk);
        i_opcode = {op, rs, rd};
        i_op_addr = instruction_address;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        acks = 0;
        for (int i = 0; i < 80 && o_done !== 1'b1; i++) begin
            if (o_bus_req === 1'b1 && i_bus_ack === 1'b1) acks++;
            if (acks == abort_at) break;
            @(negedge i_clk);
        end
        if (abort_at >= 0) begin
            i_abort = 1'b1;
            @(negedge i_clk);
            i_abort = 1'b0;
            check({o_busy, o_bus_req, o_done}, 38'h0);
            expq = {};
        end else begin
            check(o_done, 38'h1);
            check(o_next_word, fa ^ key);
            check(expq.size(), 38'h0);
            if (!form[XO_FORM_MEM_BIT]) rf[rd] = res;
            rf[14] = flags(rf[14], res, b);
        end
        rd_chk(rd);
        rd_chk(4'he);
    endtask

    initial begin
        logic [3:0] rs, rd;
        logic [7:0] op;
        void'($urandom(14982));
        rf = '{default: 16'h0000};
        repeat (6) @(negedge i_clk);
        check({o_bus_req, o_busy, o_done, o_bus_wbfd}, 38'h8);
        i_rst_b = 1'b1;
        for (int j = 0; j < 2; j++) begin
            @(negedge i_clk);
            i_opcode = {j == 0 ? 8'h58 : 8'h4f, 8'h12};
            i_start = 1'b1;
            @(negedge i_clk);
            i_start = 1'b0;
            check({o_illegal, o_busy, o_bus_req}, 38'h4);
        end
        for (int k = 0; k < 48; k++) begin
            rd = 4'($urandom_range(13, 0));
            rs = k == 0 ? rd : k % 5 == 4 ? 4'hf : 4'($urandom);
            op = k < 8 ? 8'h50 + 8'(k) : 8'h50 + 8'($urandom_range(7, 0));
            if (k == 20) run(8'h53, rs, rd, 1);
            else if (k == 30) run(8'h56, rs, rd, 3);
            else run(op, rs, rd, -1);
        end
        finish_test;
    end
endmodule // tb_top
